// File: rtl/cmif_mask_id_low.sv
// Summary of operation
// - each set has a mask-low word, bits 15:0 mask identifier 15:0, reset all ones.
// - a mask bit of 0 never blocks a match, a 1 puts that identifier bit in the compare (for a standard object only bits 28:18).
// - each set has a mask-high word, bits 12:0 mask identifier 28:16, reset ones.
// - mask-high bit 14, reset 1, puts the direction flag in the compare when set.
// - mask-high bit 15, reset 1, puts the extended flag in the compare when set.
// - each set has an identifier-low word holding identifier 15:0, reset zero.
// - a standard-identifier object takes no notice of the identifier-low bits.
// - the two sets sit at separate addresses, their identifier-low words apart.
// - identifier 28:16 lives in the identifier-high word, 17:16 unused for standard.
// - extended flag set means the 29-bit identifier, clear means the 11-bit one.
// - the mask transfer bit moves mask and both enables between buffer and object.
module cmif_mask_id_low (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // wishbone slave
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [31:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   // message object mask transfer
   input wire logic MSG_XFER_STB,
   input wire logic MSG_XFER_SET,
   input wire logic MSG_XFER_TO_OBJ,
   input wire logic MSG_XFER_MASK,
   input wire cmif_pkg::cmif_mask_type MSG_OBJ_MASK_RD,
   output cmif_pkg::cmif_mask_type MSG_OBJ_MASK_WR,
   output logic MSG_OBJ_MASK_WE,
   // acceptance filtering
   input wire logic [28:0] RX_IDENT,
   input wire logic RX_XTD,
   input wire logic RX_DIR,
   output logic [1:0] RX_MATCH
);
   import cmif_pkg::*;

   localparam int NUM_SETS = 2;

   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] rd_nxt;
   logic wb_req;
   logic wb_wr;
   logic xfer_hit;
   logic obj_we_r;
   cmif_mask_type obj_wr_r;
   cmif_reg_type acc_reg;
   logic acc_set;
   cmif_mask_type mask_a [NUM_SETS];
   cmif_ident_type ident_a [NUM_SETS];
   logic [NUM_SETS-1:0] match_a;

   cmif_set_if sif [NUM_SETS] ();

   // register decode, shared by read and write paths
   function automatic cmif_reg_type reg_of(input logic [31:0] a);
      case (a)
         CMIF_IF1_MLO_ADR, CMIF_IF2_MLO_ADR: begin
            reg_of = CMIF_R_MLO;
         end
         CMIF_IF1_MHI_ADR, CMIF_IF2_MHI_ADR: begin
            reg_of = CMIF_R_MHI;
         end
         CMIF_IF1_ILO_ADR, CMIF_IF2_ILO_ADR: begin
            reg_of = CMIF_R_ILO;
         end
         CMIF_IF1_IHI_ADR, CMIF_IF2_IHI_ADR: begin
            reg_of = CMIF_R_IHI;
         end
         default: begin
            reg_of = CMIF_R_NONE;
         end
      endcase
   endfunction

   // set 2 occupies the upper block
   function automatic logic set_of(input logic [31:0] a);
      set_of = (a >= CMIF_IF2_MLO_ADR);
   endfunction

   assign acc_reg = reg_of(ADR_I);
   assign acc_set = set_of(ADR_I);
   assign wb_req = CYC_I && STB_I;
   // a write lands on the edge that samples ack high
   assign wb_wr = wb_req && WE_I && ack_r;
   assign xfer_hit = MSG_XFER_STB && MSG_XFER_MASK;

   genvar g;
   generate
      for (g = 0; g < NUM_SETS; g = g + 1) begin : g_set
         // separate set decode
         assign sif[g].wr = wb_wr && (acc_set == 1'(g));
         assign sif[g].sel = acc_reg;
         assign sif[g].wdata = DAT_I[15:0];
         assign sif[g].be = SEL_I[1:0];
         // object load
         // the handler owns the object, so its load beats a bus write
         assign sif[g].load = xfer_hit && !MSG_XFER_TO_OBJ
                              && (MSG_XFER_SET == 1'(g));
         assign sif[g].load_mask = MSG_OBJ_MASK_RD;
         assign mask_a[g] = sif[g].mask;
         assign ident_a[g] = sif[g].ident;

         cmif_if_set u_set (
            .ref_clk(REF_CLK),
            .resetn(RESETN),
            .bus(sif[g])
         );

         cmif_accept_filter u_filt (
            .ref_clk(REF_CLK),
            .resetn(RESETN),
            .mask(mask_a[g]),
            .ident(ident_a[g]),
            .rx_id(RX_IDENT),
            .rx_xtd(RX_XTD),
            .rx_dir(RX_DIR),
            .match(match_a[g])
         );
      end
   endgenerate

   // read data
   // read mux, upper half always zero
   always_comb begin
      cmif_mask_type m;
      cmif_ident_type i;
      m = mask_a[acc_set];
      i = ident_a[acc_set];
      rd_nxt = '0;
      case (acc_reg)
         CMIF_R_MLO: begin
            rd_nxt = {CMIF_RSV_HI, m.mask[15:0]};
         end
         CMIF_R_MHI: begin
            rd_nxt = {CMIF_RSV_HI, m.extended_flag_filter_enable, m.direction_filter_enable, CMIF_RSV13_VAL,
                      m.mask[28:16]};
         end
         CMIF_R_ILO: begin
            rd_nxt = {CMIF_RSV_HI, i.id[15:0]};
         end
         // identifier 28:16 with its flags
         CMIF_R_IHI: begin
            rd_nxt = {CMIF_RSV_HI, i.msgval, i.extended_ident_flag, i.dir, i.id[28:16]};
         end
         default: begin
            rd_nxt = '0;
         end
      endcase
   end

   // one wait state; unmapped addresses still answer with zero
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req && !ack_r;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         dat_r <= '0;
      end else if (wb_req && !ack_r) begin
         dat_r <= rd_nxt;
      end
   end

   // mask write-out
   // a registered snapshot, so a bus write in the next cycle cannot tear it
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         obj_we_r <= 1'b0;
         obj_wr_r <= '0;
      end else begin
         obj_we_r <= xfer_hit && MSG_XFER_TO_OBJ;
         if (xfer_hit && MSG_XFER_TO_OBJ) begin
            obj_wr_r <= mask_a[MSG_XFER_SET];
         end
      end
   end

   assign ACK_O = ack_r;
   assign DAT_O = dat_r;
   assign MSG_OBJ_MASK_WE = obj_we_r;
   assign MSG_OBJ_MASK_WR = obj_wr_r;
   assign RX_MATCH = match_a;

   property p_rsv_zero;
      @(posedge REF_CLK) disable iff (!RESETN)
      ACK_O |-> DAT_O[31:16] == CMIF_RSV_HI;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero)
      else $error("reserved upper bits read nonzero");

   property p_ack_pulse;
      @(posedge REF_CLK) disable iff (!RESETN)
      ACK_O |=> !ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_ack_time;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_req && !ACK_O) |=> ACK_O;
   endproperty
   a_ack_time: assert property (p_ack_time)
      else $error("ack not given one cycle after request");

   property p_set_split;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_wr && ADR_I == CMIF_IF2_ILO_ADR && !sif[0].load)
         |=> $stable(ident_a[0]);
   endproperty
   a_set_split: assert property (p_set_split)
      else $error("set 2 write changed set 1 identifier");

   property p_read_mlo;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_req && !ACK_O && !WE_I && ADR_I == CMIF_IF1_MLO_ADR)
         |=> DAT_O[15:0] == $past(mask_a[0].mask[15:0]);
   endproperty
   a_read_mlo: assert property (p_read_mlo)
      else $error("mask low read data wrong");

   property p_write_ilo;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_wr && ADR_I == CMIF_IF1_ILO_ADR && SEL_I[1:0] == 2'h3)
         |=> ident_a[0].id[15:0] == $past(DAT_I[15:0]);
   endproperty
   a_write_ilo: assert property (p_write_ilo)
      else $error("identifier low write lost");

   property p_write_ihi;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_wr && ADR_I == CMIF_IF2_IHI_ADR && SEL_I[1:0] == 2'h3)
         |=> ident_a[1].id[28:16] == $past(DAT_I[12:0])
             && ident_a[1].extended_ident_flag == $past(DAT_I[CMIF_XTD_POS]);
   endproperty
   a_write_ihi: assert property (p_write_ihi)
      else $error("identifier high write lost");

   property p_xfer_out;
      @(posedge REF_CLK) disable iff (!RESETN)
      (xfer_hit && MSG_XFER_TO_OBJ) |=> MSG_OBJ_MASK_WE
         && MSG_OBJ_MASK_WR == $past(mask_a[MSG_XFER_SET]);
   endproperty
   a_xfer_out: assert property (p_xfer_out)
      else $error("mask not written out to object");

   property p_xfer_in;
      @(posedge REF_CLK) disable iff (!RESETN)
      (xfer_hit && !MSG_XFER_TO_OBJ && !MSG_XFER_SET)
         |=> mask_a[0] == $past(MSG_OBJ_MASK_RD);
   endproperty
   a_xfer_in: assert property (p_xfer_in)
      else $error("object mask not loaded into buffer");

   property p_no_xfer;
      @(posedge REF_CLK) disable iff (!RESETN)
      (MSG_XFER_STB && !MSG_XFER_MASK) |=> !MSG_OBJ_MASK_WE;
   endproperty
   a_no_xfer: assert property (p_no_xfer)
      else $error("write-out without the mask transfer bit");

   property p_mhi_fixed;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_req && !ACK_O && !WE_I && acc_reg == CMIF_R_MHI)
         |=> DAT_O[13] == CMIF_RSV13_VAL;
   endproperty
   a_mhi_fixed: assert property (p_mhi_fixed)
      else $error("mask high reserved bit not read as one");

   property p_unmapped;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_req && !ACK_O && acc_reg == CMIF_R_NONE) |=> DAT_O == '0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address read nonzero");

   property p_write_mlo;
      @(posedge REF_CLK) disable iff (!RESETN)
      (wb_wr && ADR_I == CMIF_IF2_MLO_ADR && SEL_I[1:0] == 2'h3
         && !sif[1].load)
         |=> mask_a[1].mask[15:0] == $past(DAT_I[15:0]);
   endproperty
   a_write_mlo: assert property (p_write_mlo)
      else $error("set 2 mask low write lost");

   c_write: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      wb_wr && acc_reg == CMIF_R_MHI);
   c_read: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      ACK_O && !WE_I && acc_set);
   c_xfer: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      xfer_hit ##1 xfer_hit);
   c_load: cover property (@(posedge REF_CLK) disable iff (!RESETN)
      xfer_hit && !MSG_XFER_TO_OBJ);
endmodule // cmif_mask_id_low

// File: rtl/cmif_pkg.sv
package cmif_pkg;
   // register byte addresses, interface set 1 then set 2
   localparam logic [31:0] CMIF_IF1_MLO_ADR = 32'h4005_0028;
   localparam logic [31:0] CMIF_IF1_MHI_ADR = 32'h4005_002c;
   localparam logic [31:0] CMIF_IF1_ILO_ADR = 32'h4005_0030;
   localparam logic [31:0] CMIF_IF1_IHI_ADR = 32'h4005_0034;
   localparam logic [31:0] CMIF_IF2_MLO_ADR = 32'h4005_0088;
   localparam logic [31:0] CMIF_IF2_MHI_ADR = 32'h4005_008c;
   localparam logic [31:0] CMIF_IF2_ILO_ADR = 32'h4005_0090;
   localparam logic [31:0] CMIF_IF2_IHI_ADR = 32'h4005_0094;
   // reset values
   localparam logic [15:0] CMIF_MLO_RST = 16'hffff;
   localparam logic [12:0] CMIF_MHI_RST = 13'h1fff;
   localparam logic CMIF_DIRECTION_FILTER_ENABLE_RST = 1'b1;
   localparam logic CMIF_EXTENDED_FLAG_FILTER_ENABLE_RST = 1'b1;
   localparam logic CMIF_RSV13_VAL = 1'b1;
   localparam logic [15:0] CMIF_ILO_RST = 16'h0000;
   localparam logic [12:0] CMIF_IHI_RST = 13'h0000;
   localparam logic CMIF_FLAG_RST = 1'b0;
   // field positions inside the 16 live bits of a word
   localparam int CMIF_DIRECTION_FILTER_ENABLE_POS = 14;
   localparam int CMIF_EXTENDED_FLAG_FILTER_ENABLE_POS = 15;
   localparam int CMIF_DIR_POS = 13;
   localparam int CMIF_XTD_POS = 14;
   localparam int CMIF_VAL_POS = 15;
   // identifier bits a standard object compares (28:18)
   localparam logic [28:0] CMIF_STD_CARE = 29'h1ffc_0000;
   localparam logic [28:0] CMIF_ALL_CARE = 29'h1fff_ffff;
   localparam logic [15:0] CMIF_RSV_HI = 16'h0000;

   typedef enum logic [2:0] {
      CMIF_R_NONE, CMIF_R_MLO, CMIF_R_MHI, CMIF_R_ILO, CMIF_R_IHI
   } cmif_reg_type;

   typedef struct packed {
      logic extended_flag_filter_enable;
      logic direction_filter_enable;
      logic [28:0] mask;
   } cmif_mask_type;

   typedef struct packed {
      logic msgval;
      logic extended_ident_flag;
      logic dir;
      logic [28:0] id;
   } cmif_ident_type;
endpackage // cmif_pkg

// File: rtl/cmif_set_if.sv
interface cmif_set_if;
   import cmif_pkg::*;
   logic wr;
   cmif_reg_type sel;
   logic [15:0] wdata;
   logic [1:0] be;
   logic load;
   cmif_mask_type load_mask;
   cmif_mask_type mask;
   cmif_ident_type ident;
   modport ctrl (output wr, sel, wdata, be, load, load_mask,
                 input mask, ident);
   modport regs (input wr, sel, wdata, be, load, load_mask,
                 output mask, ident);
endinterface // cmif_set_if

// File: rtl/cmif_if_set.sv
module cmif_if_set (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register access and object transfer
   cmif_set_if.regs bus
);
   import cmif_pkg::*;

   logic [15:0] mlo_r;
   logic [12:0] mhi_r;
   logic direction_filter_enable_r;
   logic extended_flag_filter_enable_r;
   logic [15:0] ilo_r;
   logic [12:0] ihi_r;
   logic dir_r;
   logic xtd_r;
   logic val_r;
   logic [15:0] mhi_nxt;
   logic [15:0] ihi_nxt;

   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] be);
      merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

   assign mhi_nxt = merge({extended_flag_filter_enable_r, direction_filter_enable_r, CMIF_RSV13_VAL, mhi_r},
                          bus.wdata, bus.be);
   assign ihi_nxt = merge({val_r, xtd_r, dir_r, ihi_r}, bus.wdata, bus.be);

   // object load beats a bus write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mlo_r <= CMIF_MLO_RST;
      end else if (bus.load) begin
         mlo_r <= bus.load_mask.mask[15:0];
      end else if (bus.wr && bus.sel == CMIF_R_MLO) begin
         mlo_r <= merge(mlo_r, bus.wdata, bus.be);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mhi_r <= CMIF_MHI_RST;
         direction_filter_enable_r <= CMIF_DIRECTION_FILTER_ENABLE_RST;
         extended_flag_filter_enable_r <= CMIF_EXTENDED_FLAG_FILTER_ENABLE_RST;
      end else if (bus.load) begin
         mhi_r <= bus.load_mask.mask[28:16];
         direction_filter_enable_r <= bus.load_mask.direction_filter_enable;
         extended_flag_filter_enable_r <= bus.load_mask.extended_flag_filter_enable;
      end else if (bus.wr && bus.sel == CMIF_R_MHI) begin
         mhi_r <= mhi_nxt[12:0];
         direction_filter_enable_r <= mhi_nxt[CMIF_DIRECTION_FILTER_ENABLE_POS];
         extended_flag_filter_enable_r <= mhi_nxt[CMIF_EXTENDED_FLAG_FILTER_ENABLE_POS];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ilo_r <= CMIF_ILO_RST;
         ihi_r <= CMIF_IHI_RST;
         dir_r <= CMIF_FLAG_RST;
         xtd_r <= CMIF_FLAG_RST;
         val_r <= CMIF_FLAG_RST;
      end else if (bus.wr && bus.sel == CMIF_R_ILO) begin
         ilo_r <= merge(ilo_r, bus.wdata, bus.be);
      end else if (bus.wr && bus.sel == CMIF_R_IHI) begin
         ihi_r <= ihi_nxt[12:0];
         dir_r <= ihi_nxt[CMIF_DIR_POS];
         xtd_r <= ihi_nxt[CMIF_XTD_POS];
         val_r <= ihi_nxt[CMIF_VAL_POS];
      end
   end

   assign bus.mask = {extended_flag_filter_enable_r, direction_filter_enable_r, mhi_r, mlo_r};
   assign bus.ident = {val_r, xtd_r, dir_r, ihi_r, ilo_r};

   property p_mlo_rst;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> mlo_r == CMIF_MLO_RST;
   endproperty
   a_mlo_rst: assert property (p_mlo_rst)
      else $error("mask low not all ones after reset");

   property p_mhi_rst;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> mhi_r == CMIF_MHI_RST && direction_filter_enable_r && extended_flag_filter_enable_r;
   endproperty
   a_mhi_rst: assert property (p_mhi_rst)
      else $error("mask high or enables wrong after reset");

   property p_ilo_rst;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> ilo_r == CMIF_ILO_RST;
   endproperty
   a_ilo_rst: assert property (p_ilo_rst)
      else $error("identifier low not zero after reset");
endmodule // cmif_if_set

// File: rtl/cmif_accept_filter.sv
module cmif_accept_filter (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // object settings
   input wire cmif_pkg::cmif_mask_type mask,
   input wire cmif_pkg::cmif_ident_type ident,
   // received frame
   input wire logic [28:0] rx_id,
   input wire logic rx_xtd,
   input wire logic rx_dir,
   output logic match
);
   import cmif_pkg::*;

   logic [28:0] care;
   logic id_ok;
   logic xtd_ok;
   logic dir_ok;

   assign care = mask.mask & (ident.extended_ident_flag ? CMIF_ALL_CARE : CMIF_STD_CARE);
   assign id_ok = ((rx_id ^ ident.id) & care) == '0;
   assign xtd_ok = !mask.extended_flag_filter_enable || (rx_xtd == ident.extended_ident_flag);
   assign dir_ok = !mask.direction_filter_enable || (rx_dir == ident.dir);

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         match <= 1'b0;
      end else begin
         match <= id_ok && xtd_ok && dir_ok;
      end
   end

   property p_open_mask;
      @(posedge ref_clk) disable iff (!resetn)
      (mask == '0) |=> match;
   endproperty
   a_open_mask: assert property (p_open_mask)
      else $error("all-zero mask failed to match");

   property p_dir_block;
      @(posedge ref_clk) disable iff (!resetn)
      (mask.direction_filter_enable && rx_dir != ident.dir) |=> !match;
   endproperty
   a_dir_block: assert property (p_dir_block)
      else $error("direction mismatch matched with enable set");

   property p_xtd_block;
      @(posedge ref_clk) disable iff (!resetn)
      (mask.extended_flag_filter_enable && rx_xtd != ident.extended_ident_flag) |=> !match;
   endproperty
   a_xtd_block: assert property (p_xtd_block)
      else $error("extended flag mismatch matched with enable set");

   property p_std_low;
      @(posedge ref_clk) disable iff (!resetn)
      (!ident.extended_ident_flag && rx_id[28:18] == ident.id[28:18]
         && rx_xtd == ident.extended_ident_flag && rx_dir == ident.dir) |=> match;
   endproperty
   a_std_low: assert property (p_std_low)
      else $error("standard object blocked by low identifier bits");

   property p_ext_full;
      @(posedge ref_clk) disable iff (!resetn)
      (ident.extended_ident_flag && mask.mask == CMIF_ALL_CARE && rx_id != ident.id)
         |=> !match;
   endproperty
   a_ext_full: assert property (p_ext_full)
      else $error("extended object matched a different identifier");

   c_match: cover property (@(posedge ref_clk) disable iff (!resetn)
      $rose(match));
endmodule // cmif_accept_filter

// File: verification/cmif_mask_id_low_test.sv
module cmif_mask_id_low_test;
   timeunit 1ns;
   timeprecision 100ps;
   import cmif_pkg::*;

   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [31:0] adr_i = 32'h0000_0000;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack_o;
   logic xfer_stb = 1'b0;
   logic xfer_set = 1'b0;
   logic xfer_to_obj = 1'b0;
   logic xfer_mask = 1'b0;
   cmif_mask_type obj_rd = '0;
   cmif_mask_type obj_wr;
   logic obj_we;
   logic [28:0] rx_ident = 29'h0000_0000;
   logic rx_xtd = 1'b0;
   logic rx_dir = 1'b0;
   logic [1:0] rx_match;
   int num_errors = 0;
   int n_checks = 0;
   logic [15:0] lfsr = 16'ha0d1;
   // model words: set*4 + {mask low, mask high, ident low, ident high}
   int mdl[8];
   logic [31:0] adr_tab[8] = '{CMIF_IF1_MLO_ADR, CMIF_IF1_MHI_ADR,
      CMIF_IF1_ILO_ADR, CMIF_IF1_IHI_ADR, CMIF_IF2_MLO_ADR,
      CMIF_IF2_MHI_ADR, CMIF_IF2_ILO_ADR, CMIF_IF2_IHI_ADR};

   cmif_mask_id_low i_cmif_mask_id_low (
      .REF_CLK(ref_clk), .RESETN(resetn), .CYC_I(cyc_i), .STB_I(stb_i),
      .WE_I(we_i), .ADR_I(adr_i), .SEL_I(sel_i), .DAT_I(dat_i),
      .DAT_O(dat_o), .ACK_O(ack_o), .MSG_XFER_STB(xfer_stb),
      .MSG_XFER_SET(xfer_set), .MSG_XFER_TO_OBJ(xfer_to_obj),
      .MSG_XFER_MASK(xfer_mask), .MSG_OBJ_MASK_RD(obj_rd),
      .MSG_OBJ_MASK_WR(obj_wr), .MSG_OBJ_MASK_WE(obj_we),
      .RX_IDENT(rx_ident), .RX_XTD(rx_xtd), .RX_DIR(rx_dir),
      .RX_MATCH(rx_match));

   always #12.5 ref_clk = ~ref_clk;

   function automatic logic [15:0] rnd();
      lfsr = lfsr[0] ? ((lfsr >> 1) ^ 16'hb400) : (lfsr >> 1);
      return lfsr;
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic ok, input string what);
      n_checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("ERROR %0t: %s", $time, what);
      end
   endtask
   task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
      check(got === exp, $sformatf("read %h expected %h", got, exp));
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      check(got === exp, $sformatf("strobe %b expected %b", got, exp));
   endtask
   task automatic cmp_obj(input logic [30:0] got, input logic [30:0] exp);
      check(got === exp, $sformatf("object %h expected %h", got, exp));
   endtask
   task automatic cmp_match(input logic [1:0] got, input logic [1:0] exp);
      check(got === exp, $sformatf("match %b expected %b", got, exp));
   endtask

   function automatic void mdl_reset();
      for (int k = 0; k < 2; k++) begin
         mdl[4*k] = 'hffff;
         mdl[4*k+1] = 'hffff;
         mdl[4*k+2] = 0;
         mdl[4*k+3] = 0;
      end
   endfunction

   // only the lanes selected in the low half land; bit 13 of mask high is fixed
   function automatic void mdl_wr(int i, logic [31:0] d, logic [3:0] s);
      logic [15:0] v;
      v = mdl[i][15:0];
      if (s[0]) v[7:0] = d[7:0];
      if (s[1]) v[15:8] = d[15:8];
      if (i % 4 == 1) v[13] = 1'b1;
      mdl[i] = v;
   endfunction

   function automatic logic [30:0] obj_of(int k);
      logic [15:0] mh;
      mh = mdl[4*k+1][15:0];
      return {mh[15], mh[14], mh[12:0], mdl[4*k][15:0]};
   endfunction

   function automatic logic exp_match(int k);
      logic [15:0] mh;
      logic [15:0] ih;
      logic [28:0] msk;
      logic [28:0] id;
      logic [28:0] care;
      mh = mdl[4*k+1][15:0];
      ih = mdl[4*k+3][15:0];
      msk = {mh[12:0], mdl[4*k][15:0]};
      id = {ih[12:0], mdl[4*k+2][15:0]};
      care = ih[14] ? 29'h1fff_ffff : 29'h1ffc_0000;
      return (((rx_ident ^ id) & msk & care) == 29'h0) &&
         (!mh[15] || rx_xtd == ih[14]) && (!mh[14] || rx_dir == ih[13]);
   endfunction

   task automatic wb(input logic we, input logic [31:0] adr,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      int n;
      @(posedge ref_clk);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      dat_i <= d;
      sel_i <= s;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack_o !== 1'b1 && n < 40);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 40) check(1'b0, "no bus answer");
      @(posedge ref_clk);
      cmp_flag(ack_o, 1'b0);
   endtask

   task automatic reg_wr(input int i, input logic [31:0] d,
                         input logic [3:0] s);
      logic [31:0] q;
      wb(1'b1, adr_tab[i], d, s, q);
      mdl_wr(i, d, s);
   endtask
   task automatic reg_rd(input int i);
      logic [31:0] q;
      wb(1'b0, adr_tab[i], 32'h0000_0000, 4'hf, q);
      cmp_rd(q, mdl[i]);
   endtask

   task automatic xfer(input logic set, input logic to_obj, input logic msk);
      logic [15:0] a;
      logic [15:0] b;
      a = rnd();
      b = rnd();
      @(posedge ref_clk);
      xfer_stb <= 1'b1;
      xfer_set <= set;
      xfer_to_obj <= to_obj;
      xfer_mask <= msk;
      obj_rd <= {a[14:0], b};
      @(posedge ref_clk);
      xfer_stb <= 1'b0;
      obj_rd <= ~{a[14:0], b};
      if (msk && !to_obj) begin
         mdl[4*set] = b;
         mdl[4*set+1] = {a[14], a[13], 1'b1, a[12:0]};
      end
      @(posedge ref_clk);
      cmp_flag(obj_we, msk & to_obj);
      if (msk && to_obj) cmp_obj(obj_wr, obj_of(set));
      @(posedge ref_clk);
      cmp_flag(obj_we, 1'b0);
   endtask

   task automatic filt();
      logic [15:0] a;
      int k;
      a = rnd();
      k = a[1] ? 4 : 0;
      @(posedge ref_clk);
      rx_ident <= {mdl[k+3][12:0], mdl[k+2][15:0]} ^
         (a[0] ? (29'h1 << (a[15:11] % 29)) : 29'h0);
      rx_xtd <= a[2] ? mdl[k+3][14] : a[3];
      rx_dir <= a[4] ? mdl[k+3][13] : a[5];
      repeat (2) @(posedge ref_clk);
      cmp_match(rx_match, {exp_match(1), exp_match(0)});
   endtask

   initial begin
      repeat (30000) @(posedge ref_clk);
      check(1'b0, "watchdog expired");
      tally_and_finish();
   end

   initial begin
      logic [31:0] q;
      logic [15:0] a;
      logic [15:0] b;
      mdl_reset();
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 8; i++) reg_rd(i);
      filt();
      $display("test reset values done");
      reg_wr(2, 32'hffff_5a5a, 4'hf);
      reg_rd(6);
      reg_rd(2);
      for (int r = 0; r < 40; r++) begin
         a = rnd();
         b = rnd();
         reg_wr(a % 8, {b, rnd()}, a[7:4]);
         reg_rd(b % 8);
      end
      wb(1'b1, 32'h4005_0038, 32'hffff_ffff, 4'hf, q);
      wb(1'b1, 32'h0000_0028, 32'h0000_1234, 4'hf, q);
      wb(1'b0, 32'h4005_0038, 32'h0000_0000, 4'hf, q);
      cmp_rd(q, 32'h0000_0000);
      for (int i = 0; i < 8; i++) reg_rd(i);
      $display("test register access done");
      for (int c = 0; c < 16; c++) begin
         xfer(c[0], c[1], c[2]);
         reg_rd(4 * c[0]);
         reg_rd(4 * c[0] + 1);
      end
      $display("test object transfer done");
      reg_wr(0, 32'h0000_0000, 4'h3);
      reg_wr(1, 32'h0000_0000, 4'h3);
      for (int r = 0; r < 6; r++) filt();
      for (int r = 0; r < 80; r++) begin
         a = rnd();
         if (a[3:2] != 2'b00) reg_wr(a % 8, {rnd(), rnd()}, 4'h3);
         filt();
      end
      $display("test acceptance filter done");
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      mdl_reset();
      @(posedge ref_clk);
      cmp_flag(obj_we, 1'b0);
      cmp_rd(dat_o, 32'h0000_0000);
      for (int i = 0; i < 8; i++) reg_rd(i);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule // cmif_mask_id_low_test
